// ### design/cpu_regs_consts.vh
// Constants for the core register set and flag logic
// What this block does
// - Four 16-bit data registers serve as operands and destinations.
// - Data registers zero and one split into separate high and low bytes.
// - Pairs: two over zero, three over one, form 32-bit registers.
// - Two 24-bit address registers for indirect, relative and data use.
// - 24-bit static base register for static-base-relative addressing.
// - 24-bit frame base register for frame-relative addressing.
// - Two 24-bit stack pointers; stack-select flag picks the active one.
// - 24-bit vector table base holds relocatable vector table start.
// - 24-bit program counter holds the next instruction address.
// - 16-bit flag register holds the condition and control flags.
// - Carry flag updated after each instruction for carry or borrow.
// - Zero flag is 1 for a zero result, else 0.
// - Sign flag is 1 for a negative result, else 0.
// - Bank-select flag 0 picks bank 0, 1 picks bank 1.
// - Overflow flag is 1 on arithmetic overflow, else 0.
`ifndef CPU_REGS_CONSTS_VH
`define CPU_REGS_CONSTS_VH

// Register select codes on the access port
`define SEL_DATA0      4'h0
`define SEL_DATA1      4'h1
`define SEL_DATA2      4'h2
`define SEL_DATA3      4'h3
`define SEL_ADDR0      4'h4
`define SEL_ADDR1      4'h5
`define SEL_SBASE      4'h6
`define SEL_FBASE      4'h7
`define SEL_USP        4'h8
`define SEL_ISP        4'h9
`define SEL_VTB        4'hA
`define SEL_PC         4'hB
`define SEL_FLAGS      4'hC
`define SEL_SP         4'hD
`define SEL_PAIR_LOW   4'hE
`define SEL_PAIR_HIGH  4'hF

// Access width codes
`define WID_BYTE_LOW   2'h0
`define WID_BYTE_HIGH  2'h1
`define WID_WORD       2'h2
`define WID_FULL       2'h3

// Flag register bit positions
`define FLG_CARRY      0
`define FLG_DEBUG      1
`define FLG_ZERO       2
`define FLG_SIGN       3
`define FLG_BANK       4
`define FLG_OVFL       5
`define FLG_STACK      7

// Writable flag bits; the rest read as zero
`define FLG_MASK       16'h00BF
`define FLG_RESET      16'h0000
`define REG_RESET      24'h000000

`endif

// ### design/cpu_register_file_and_flags.v
// Core register set, banked copies, stack select and flag register
//
// Decided for this implementation: the register offsets and strobed register access.
`include "cpu_regs_consts.vh"

module cpu_register_file_and_flags (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Register access port, write takes effect at the clock edge
  input  wire [3:0]  rd_sel_i,
  input  wire [1:0]  rd_width_i,
  output reg  [31:0] rd_data_o,
  input  wire        wr_en_i,
  input  wire [3:0]  wr_sel_i,
  input  wire [1:0]  wr_width_i,
  input  wire [31:0] wr_data_i,
  // Program counter
  input  wire        pc_load_i,
  input  wire [23:0] pc_load_value_i,
  input  wire        pc_inc_i,
  input  wire [2:0]  pc_inc_amount_i,
  // Result flag update at the end of an instruction
  input  wire        flag_update_i,
  input  wire [1:0]  res_width_i,
  input  wire [31:0] res_value_i,
  input  wire        res_carry_i,
  input  wire        res_ovfl_i,
  input  wire        res_zs_en_i,
  input  wire        res_ov_en_i,
  // Direct control of bank and stack select flags
  input  wire        bank_set_i,
  input  wire        bank_value_i,
  input  wire        stack_set_i,
  input  wire        stack_value_i,
  // Always-visible state for address generation
  output reg  [23:0] pc_o,
  output reg  [23:0] active_sp_o,
  output reg  [23:0] static_base_o,
  output reg  [23:0] frame_base_o,
  output reg  [23:0] vector_table_base_o,
  output reg  [15:0] flag_register_o
);

  // Banked storage: data0..3, addr0..1, static base, frame base
  reg [15:0] data_reg_zero  [0:1];
  reg [15:0] data_reg_one   [0:1];
  reg [15:0] data_reg_two   [0:1];
  reg [15:0] data_reg_three [0:1];
  reg [23:0] addr_reg_zero  [0:1];
  reg [23:0] addr_reg_one   [0:1];
  reg [23:0] static_base    [0:1];
  reg [23:0] frame_base     [0:1];
  reg [23:0] user_stack_pointer;
  reg [23:0] interrupt_stack_pointer;

  wire       bank;
  wire       stack_user;
  assign bank       = flag_register_o[`FLG_BANK];
  assign stack_user = flag_register_o[`FLG_STACK];

  // Merge a write of a given width into a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [1:0]  width;
    input [31:0] data;
    begin
      case (width)
        `WID_BYTE_LOW:  merge16 = {old[15:8], data[7:0]};
        `WID_BYTE_HIGH: merge16 = {data[7:0], old[7:0]};
        default:        merge16 = data[15:0];
      endcase
    end
  endfunction

  // Merge into a 24-bit register; word writes keep the top byte
  function [23:0] merge24;
    input [23:0] old;
    input [1:0]  width;
    input [31:0] data;
    begin
      case (width)
        `WID_BYTE_LOW:  merge24 = {old[23:8], data[7:0]};
        `WID_BYTE_HIGH: merge24 = {old[23:16], data[7:0], old[7:0]};
        `WID_WORD:      merge24 = {old[23:16], data[15:0]};
        default:        merge24 = data[23:0];
      endcase
    end
  endfunction

  // Read a 16-bit register at a width, zero extended
  function [31:0] view16;
    input [15:0] val;
    input [1:0]  width;
    begin
      case (width)
        `WID_BYTE_LOW:  view16 = {24'h000000, val[7:0]};
        `WID_BYTE_HIGH: view16 = {24'h000000, val[15:8]};
        default:        view16 = {16'h0000, val};
      endcase
    end
  endfunction

  function [31:0] view24;
    input [23:0] val;
    input [1:0]  width;
    begin
      case (width)
        `WID_BYTE_LOW:  view24 = {24'h000000, val[7:0]};
        `WID_BYTE_HIGH: view24 = {24'h000000, val[15:8]};
        `WID_WORD:      view24 = {16'h0000, val[15:0]};
        default:        view24 = {8'h00, val};
      endcase
    end
  endfunction

  // Match a write strobe against one register select
  function wr_hit;
    input       en;
    input [3:0] sel;
    input [3:0] target;
    begin
      wr_hit = en && (sel == target);
    end
  endfunction

  // Write decodes used by the combinational next-value logic
  wire wr_flags;
  wire wr_usp;
  wire wr_isp;
  wire wr_sp;
  wire wr_sbase;
  wire wr_fbase;
  assign wr_flags = wr_hit(wr_en_i, wr_sel_i, `SEL_FLAGS);
  assign wr_usp   = wr_hit(wr_en_i, wr_sel_i, `SEL_USP);
  assign wr_isp   = wr_hit(wr_en_i, wr_sel_i, `SEL_ISP);
  assign wr_sp    = wr_hit(wr_en_i, wr_sel_i, `SEL_SP);
  assign wr_sbase = wr_hit(wr_en_i, wr_sel_i, `SEL_SBASE);
  assign wr_fbase = wr_hit(wr_en_i, wr_sel_i, `SEL_FBASE);

  // Read mux, combinational into the registered read data
  reg [31:0] next_rd_data;
  always @* begin
    case (rd_sel_i)
      `SEL_DATA0: next_rd_data = view16(data_reg_zero[bank], rd_width_i);
      `SEL_DATA1: next_rd_data = view16(data_reg_one[bank], rd_width_i);
      `SEL_DATA2: next_rd_data = view16(data_reg_two[bank], rd_width_i);
      `SEL_DATA3: next_rd_data = view16(data_reg_three[bank], rd_width_i);
      `SEL_ADDR0: next_rd_data = view24(addr_reg_zero[bank], rd_width_i);
      `SEL_ADDR1: next_rd_data = view24(addr_reg_one[bank], rd_width_i);
      `SEL_SBASE: next_rd_data = view24(static_base[bank], rd_width_i);
      `SEL_FBASE: next_rd_data = view24(frame_base[bank], rd_width_i);
      `SEL_USP:   next_rd_data = view24(user_stack_pointer, rd_width_i);
      `SEL_ISP:   next_rd_data = view24(interrupt_stack_pointer,
                                        rd_width_i);
      `SEL_VTB:   next_rd_data = view24(vector_table_base_o, rd_width_i);
      `SEL_PC:    next_rd_data = view24(pc_o, rd_width_i);
      `SEL_FLAGS: next_rd_data = {16'h0000, flag_register_o};
      `SEL_SP:    next_rd_data = view24(active_sp_o, rd_width_i);
      `SEL_PAIR_LOW:
        next_rd_data = {data_reg_two[bank], data_reg_zero[bank]};
      `SEL_PAIR_HIGH:
        next_rd_data = {data_reg_three[bank], data_reg_one[bank]};
      default:    next_rd_data = 32'h00000000;
    endcase
  end

  // Result classification by operand width
  reg res_zero;
  reg res_neg;
  always @* begin
    case (res_width_i)
      `WID_BYTE_LOW, `WID_BYTE_HIGH: begin
        res_zero = (res_value_i[7:0] == 8'h00);
        res_neg  = res_value_i[7];
      end
      `WID_WORD: begin
        res_zero = (res_value_i[15:0] == 16'h0000);
        res_neg  = res_value_i[15];
      end
      default: begin
        res_zero = (res_value_i == 32'h00000000);
        res_neg  = res_value_i[31];
      end
    endcase
  end

  // Flag register next value; result flags win over a direct write
  reg [15:0] next_flags;
  always @* begin
    next_flags = flag_register_o;
    if (wr_flags) begin
      next_flags = wr_data_i[15:0] & `FLG_MASK;
    end
    if (bank_set_i) begin
      next_flags[`FLG_BANK] = bank_value_i;
    end
    if (stack_set_i) begin
      next_flags[`FLG_STACK] = stack_value_i;
    end
    if (flag_update_i) begin
      next_flags[`FLG_CARRY] = res_carry_i;
      if (res_zs_en_i) begin
        next_flags[`FLG_ZERO] = res_zero;
        next_flags[`FLG_SIGN] = res_neg;
      end
      if (res_ov_en_i) begin
        next_flags[`FLG_OVFL] = res_ovfl_i;
      end
    end
  end

  // Outputs are registered from next values so they move on the same
  // edge as the storage behind them
  reg  [23:0] next_usp;
  reg  [23:0] next_isp;
  reg  [23:0] next_active_sp;
  reg  [23:0] next_static_base;
  reg  [23:0] next_frame_base;
  wire        next_bank;
  assign next_bank = next_flags[`FLG_BANK];
  always @* begin
    next_usp = user_stack_pointer;
    next_isp = interrupt_stack_pointer;
    if (wr_usp || (wr_sp && stack_user)) begin
      next_usp = merge24(user_stack_pointer, wr_width_i, wr_data_i);
    end
    if (wr_isp || (wr_sp && !stack_user)) begin
      next_isp = merge24(interrupt_stack_pointer, wr_width_i, wr_data_i);
    end
    next_active_sp = next_flags[`FLG_STACK] ? next_usp : next_isp;
  end

  // A base write lands in the bank in force now; after a same-cycle
  // bank switch the output shows the other, untouched copy
  always @* begin
    next_static_base = static_base[next_bank];
    next_frame_base  = frame_base[next_bank];
    if (wr_sbase && next_bank == bank) begin
      next_static_base = merge24(static_base[bank], wr_width_i,
                                 wr_data_i);
    end
    if (wr_fbase && next_bank == bank) begin
      next_frame_base = merge24(frame_base[bank], wr_width_i,
                                wr_data_i);
    end
  end

  // Address-generation outputs, registered
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_sp_o   <= `REG_RESET;
      static_base_o <= `REG_RESET;
      frame_base_o  <= `REG_RESET;
    end else begin
      active_sp_o   <= next_active_sp;
      static_base_o <= next_static_base;
      frame_base_o  <= next_frame_base;
    end
  end

  wire wr_pc;
  assign wr_pc = wr_hit(wr_en_i, wr_sel_i, `SEL_PC);

  // Banked writes use the bank in force now; a bank switch in the same
  // cycle affects only later accesses
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg_zero[0]        <= 16'h0000;
      data_reg_zero[1]        <= 16'h0000;
      data_reg_one[0]         <= 16'h0000;
      data_reg_one[1]         <= 16'h0000;
      data_reg_two[0]         <= 16'h0000;
      data_reg_two[1]         <= 16'h0000;
      data_reg_three[0]       <= 16'h0000;
      data_reg_three[1]       <= 16'h0000;
      addr_reg_zero[0]        <= `REG_RESET;
      addr_reg_zero[1]        <= `REG_RESET;
      addr_reg_one[0]         <= `REG_RESET;
      addr_reg_one[1]         <= `REG_RESET;
      static_base[0]          <= `REG_RESET;
      static_base[1]          <= `REG_RESET;
      frame_base[0]           <= `REG_RESET;
      frame_base[1]           <= `REG_RESET;
      user_stack_pointer      <= `REG_RESET;
      interrupt_stack_pointer <= `REG_RESET;
      vector_table_base_o     <= `REG_RESET;
      pc_o                    <= `REG_RESET;
      flag_register_o         <= `FLG_RESET;
      rd_data_o               <= 32'h00000000;
    end else begin
      rd_data_o       <= next_rd_data;
      flag_register_o <= next_flags;
      if (wr_pc) begin
        pc_o <= wr_data_i[23:0];
      end else if (pc_load_i) begin
        pc_o <= pc_load_value_i;
      end else if (pc_inc_i) begin
        pc_o <= pc_o + {21'h00000, pc_inc_amount_i};
      end
      if (wr_en_i) begin
        case (wr_sel_i)
          `SEL_DATA0: data_reg_zero[bank] <=
            merge16(data_reg_zero[bank], wr_width_i, wr_data_i);
          `SEL_DATA1: data_reg_one[bank] <=
            merge16(data_reg_one[bank], wr_width_i, wr_data_i);
          `SEL_DATA2: data_reg_two[bank] <= wr_data_i[15:0];
          `SEL_DATA3: data_reg_three[bank] <= wr_data_i[15:0];
          `SEL_ADDR0: addr_reg_zero[bank] <=
            merge24(addr_reg_zero[bank], wr_width_i, wr_data_i);
          `SEL_ADDR1: addr_reg_one[bank] <=
            merge24(addr_reg_one[bank], wr_width_i, wr_data_i);
          `SEL_SBASE: static_base[bank] <=
            merge24(static_base[bank], wr_width_i, wr_data_i);
          `SEL_FBASE: frame_base[bank] <=
            merge24(frame_base[bank], wr_width_i, wr_data_i);
          `SEL_USP: user_stack_pointer <=
            merge24(user_stack_pointer, wr_width_i, wr_data_i);
          `SEL_ISP: interrupt_stack_pointer <=
            merge24(interrupt_stack_pointer, wr_width_i, wr_data_i);
          `SEL_VTB: vector_table_base_o <=
            merge24(vector_table_base_o, wr_width_i, wr_data_i);
          `SEL_SP: begin
            if (stack_user) begin
              user_stack_pointer <= merge24(user_stack_pointer,
                                            wr_width_i, wr_data_i);
            end else begin
              interrupt_stack_pointer <= merge24(interrupt_stack_pointer,
                                                 wr_width_i, wr_data_i);
            end
          end
          `SEL_PAIR_LOW: begin
            data_reg_two[bank]  <= wr_data_i[31:16];
            data_reg_zero[bank] <= wr_data_i[15:0];
          end
          `SEL_PAIR_HIGH: begin
            data_reg_three[bank] <= wr_data_i[31:16];
            data_reg_one[bank]   <= wr_data_i[15:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

// ### verif/cpu_regs_props.sv
// Concurrent checks on the register file and flag ports
`include "cpu_regs_consts.vh"
module cpu_regs_props (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wr_en_i,
  input wire logic [3:0]  wr_sel_i,
  input wire logic        pc_load_i,
  input wire logic [23:0] pc_load_value_i,
  input wire logic        pc_inc_i,
  input wire logic [2:0]  pc_inc_amount_i,
  input wire logic        flag_update_i,
  input wire logic [1:0]  res_width_i,
  input wire logic [31:0] res_value_i,
  input wire logic        res_carry_i,
  input wire logic        res_ovfl_i,
  input wire logic        res_zs_en_i,
  input wire logic        res_ov_en_i,
  input wire logic        bank_set_i,
  input wire logic        bank_value_i,
  input wire logic        stack_set_i,
  input wire logic        stack_value_i,
  input wire logic [23:0] pc_o,
  input wire logic [15:0] flag_register_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire pc_wr = wr_en_i && wr_sel_i == `SEL_PC;
  wire zs_word = flag_update_i && res_zs_en_i && res_width_i == `WID_WORD;
  wire res_zero = res_value_i[15:0] == 16'h0000;
  wire res_neg = res_value_i[15];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_pc_load_value: assert property (pc_load_i && !pc_wr |=>
    pc_o == $past(pc_load_value_i)) else $error("pc load lost");
  a_pc_inc_step: assert property (pc_inc_i && !pc_load_i && !pc_wr |=>
    pc_o == $past(pc_o) + $past(pc_inc_amount_i)) else $error("pc step");
  a_carry_load: assert property (flag_update_i |=>
    flag_register_o[`FLG_CARRY] == $past(res_carry_i)) else $error("carry");
  a_zero_flag: assert property (zs_word |=>
    flag_register_o[`FLG_ZERO] == $past(res_zero)) else $error("zero");
  a_sign_flag: assert property (zs_word |=>
    flag_register_o[`FLG_SIGN] == $past(res_neg)) else $error("sign");
  a_ovfl_flag: assert property (flag_update_i && res_ov_en_i |=>
    flag_register_o[`FLG_OVFL] == $past(res_ovfl_i)) else $error("ovfl");
  a_bank_select: assert property (bank_set_i |=>
    flag_register_o[`FLG_BANK] == $past(bank_value_i)) else $error("bank");
  a_stack_select: assert property (stack_set_i |=>
    flag_register_o[`FLG_STACK] == $past(stack_value_i)) else $error("stk");
  a_flag_reserved: assert property (flag_register_o[15:8] == 8'h00 &&
    !flag_register_o[6]) else $error("reserved flag bits set");
  a_debug_clear: assert property (
    !flag_register_o[`FLG_DEBUG]) else $error("debug flag set");
endmodule
bind cpu_register_file_and_flags cpu_regs_props chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i),
  .pc_load_i(pc_load_i), .pc_load_value_i(pc_load_value_i),
  .pc_inc_i(pc_inc_i), .pc_inc_amount_i(pc_inc_amount_i),
  .flag_update_i(flag_update_i), .res_width_i(res_width_i),
  .res_value_i(res_value_i), .res_carry_i(res_carry_i),
  .res_ovfl_i(res_ovfl_i), .res_zs_en_i(res_zs_en_i),
  .res_ov_en_i(res_ov_en_i), .bank_set_i(bank_set_i),
  .bank_value_i(bank_value_i), .stack_set_i(stack_set_i),
  .stack_value_i(stack_value_i), .pc_o(pc_o),
  .flag_register_o(flag_register_o));

// ### verif/alu_seq_model.sv
// ALU and sequencer model: a 16-bit add ending in a flag update
`include "cpu_regs_consts.vh"
module alu_seq_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  output logic             flag_update_o,
  output logic [1:0]       res_width_o,
  output logic [31:0]      res_value_o,
  output logic             res_carry_o,
  output logic             res_ovfl_o,
  output logic             res_zs_en_o,
  output logic             res_ov_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] sum;
  assign sum = {1'b0, a_i} + {1'b0, b_i};
  // Result launched one cycle after go, as the sequencer would
  always @(posedge clk_i) begin
    flag_update_o <= go_i;
    res_zs_en_o   <= go_i;
    res_ov_en_o   <= go_i;
    res_width_o   <= `WID_WORD;
    res_carry_o   <= sum[16];
    res_ovfl_o    <= a_i[15] == b_i[15] && sum[15] != a_i[15];
    res_value_o   <= {16'h0000, sum[15:0]};
  end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the core register file and flags
`include "cpu_regs_consts.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
  end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, wr_en_i, pc_load_i, pc_inc_i, go;
  logic bank_set_i, bank_value_i, stack_set_i, stack_value_i;
  logic [3:0] rd_sel_i, wr_sel_i;
  logic [1:0] rd_width_i, wr_width_i, res_w;
  logic [31:0] wr_data_i, res_v;
  logic [23:0] pc_load_value_i;
  logic [2:0] pc_inc_amount_i;
  logic [15:0] op_a, op_b;
  logic fu, rc, ro, rz, rv;
  wire [31:0] rd_data_o;
  wire [23:0] pc_o, active_sp_o, static_base_o, frame_base_o, vtb_o;
  wire [15:0] flag_register_o;
  logic [3:0] sels [0:4];
  int n_fail, samples_checked, cycles;
  cpu_register_file_and_flags uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rd_sel_i(rd_sel_i), .rd_width_i(rd_width_i), .rd_data_o(rd_data_o),
    .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i), .wr_width_i(wr_width_i),
    .wr_data_i(wr_data_i), .pc_load_i(pc_load_i),
    .pc_load_value_i(pc_load_value_i), .pc_inc_i(pc_inc_i),
    .pc_inc_amount_i(pc_inc_amount_i), .flag_update_i(fu),
    .res_width_i(res_w), .res_value_i(res_v), .res_carry_i(rc),
    .res_ovfl_i(ro), .res_zs_en_i(rz), .res_ov_en_i(rv),
    .bank_set_i(bank_set_i), .bank_value_i(bank_value_i),
    .stack_set_i(stack_set_i), .stack_value_i(stack_value_i),
    .pc_o(pc_o), .active_sp_o(active_sp_o), .static_base_o(static_base_o),
    .frame_base_o(frame_base_o), .vector_table_base_o(vtb_o),
    .flag_register_o(flag_register_o));
  alu_seq_model alu_m (.clk_i(clk_i), .go_i(go), .a_i(op_a), .b_i(op_b),
    .flag_update_o(fu), .res_width_o(res_w), .res_value_o(res_v),
    .res_carry_o(rc), .res_ovfl_o(ro), .res_zs_en_o(rz), .res_ov_en_o(rv));
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] s, input logic [1:0] w,
                    input logic [31:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1; wr_sel_i <= s; wr_width_i <= w; wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] s, input logic [1:0] w,
                    input logic [31:0] e);
    @(posedge clk_i);
    rd_sel_i <= s; rd_width_i <= w;
    @(posedge clk_i);
    #1 `CHK(rd_data_o, e)
  endtask
  task automatic ctl(input logic bank, input logic v);
    @(posedge clk_i);
    bank_set_i <= bank; stack_set_i <= !bank;
    bank_value_i <= v; stack_value_i <= v;
    @(posedge clk_i);
    bank_set_i <= 1'b0; stack_set_i <= 1'b0;
    #1;
  endtask
  task automatic pco(input logic ld, input logic [23:0] v,
                     input logic [2:0] n);
    @(posedge clk_i);
    pc_load_i <= ld; pc_inc_i <= !ld; pc_load_value_i <= v;
    pc_inc_amount_i <= n;
    @(posedge clk_i);
    pc_load_i <= 1'b0; pc_inc_i <= 1'b0;
  endtask
  task automatic alu(input logic [15:0] a, b, input logic [15:0] e);
    @(posedge clk_i);
    go <= 1'b1; op_a <= a; op_b <= b;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    #1 `CHK(flag_register_o, e)
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Hang guard, far above the roughly 110 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {wr_en_i, pc_load_i, pc_inc_i, go, bank_set_i, bank_value_i} = '0;
    {stack_set_i, stack_value_i, rd_sel_i, wr_sel_i} = '0;
    {rd_width_i, wr_width_i, wr_data_i, pc_load_value_i} = '0;
    {pc_inc_amount_i, op_a, op_b} = '0;
    sels = '{`SEL_ADDR0, `SEL_ADDR1, `SEL_SBASE, `SEL_FBASE, `SEL_VTB};
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 `CHK(pc_o, 24'h000000)
    `CHK(flag_register_o, 16'h0000)
    wr(`SEL_DATA3, `WID_WORD, 32'h0000A5C3);
    rd(`SEL_DATA3, `WID_WORD, 32'h0000A5C3);
    wr(`SEL_DATA0, `WID_WORD, 32'h00001234);
    wr(`SEL_DATA0, `WID_BYTE_HIGH, 32'h000000AB);
    rd(`SEL_DATA0, `WID_WORD, 32'h0000AB34);
    rd(`SEL_DATA0, `WID_BYTE_LOW, 32'h00000034);
    rd(`SEL_DATA0, `WID_BYTE_HIGH, 32'h000000AB);
    wr(`SEL_DATA1, `WID_BYTE_LOW, 32'h0000005A);
    wr(`SEL_DATA2, `WID_WORD, 32'h00005678);
    rd(`SEL_PAIR_LOW, `WID_FULL, 32'h5678AB34);
    rd(`SEL_PAIR_HIGH, `WID_FULL, 32'hA5C3005A);
    for (int i = 0; i < 5; i++) begin
      wr(sels[i], `WID_FULL, 32'h00C0FF00 + i);
      rd(sels[i], `WID_FULL, 32'h00C0FF00 + i);
    end
    `CHK(static_base_o, 24'hC0FF02)
    `CHK(frame_base_o, 24'hC0FF03)
    `CHK(vtb_o, 24'hC0FF04)
    wr(`SEL_ADDR0, `WID_BYTE_HIGH, 32'h00000055);
    rd(`SEL_ADDR0, `WID_FULL, 32'h00C05500);
    rd(`SEL_ADDR0, `WID_BYTE_HIGH, 32'h00000055);
    wr(`SEL_USP, `WID_FULL, 32'h00001000);
    wr(`SEL_ISP, `WID_FULL, 32'h00002000);
    rd(`SEL_SP, `WID_FULL, 32'h00002000);
    ctl(1'b0, 1'b1);
    `CHK(active_sp_o, 24'h001000)
    wr(`SEL_SP, `WID_WORD, 32'h00003456);
    rd(`SEL_USP, `WID_FULL, 32'h00003456);
    `CHK(active_sp_o, 24'h003456)
    rd(`SEL_ISP, `WID_FULL, 32'h00002000);
    ctl(1'b0, 1'b0);
    ctl(1'b1, 1'b1);
    `CHK(static_base_o, 24'h000000)
    wr(`SEL_DATA0, `WID_WORD, 32'h0000BEEF);
    rd(`SEL_DATA0, `WID_WORD, 32'h0000BEEF);
    ctl(1'b1, 1'b0);
    rd(`SEL_DATA0, `WID_WORD, 32'h0000AB34);
    pco(1'b1, 24'h00FFFE, 3'h0);
    pco(1'b0, 24'h000000, 3'h4);
    #1 `CHK(pc_o, 24'h010002)
    wr(`SEL_PC, `WID_FULL, 32'h00123456);
    rd(`SEL_PC, `WID_FULL, 32'h00123456);
    wr(`SEL_FLAGS, `WID_WORD, 32'h0000FFFD);
    rd(`SEL_FLAGS, `WID_WORD, 32'h000000BD);
    wr(`SEL_FLAGS, `WID_WORD, 32'h00000000);
    alu(16'h8000, 16'h8000, 16'h0025);
    alu(16'h7FFF, 16'h0001, 16'h0028);
    alu(16'hFFFF, 16'h0001, 16'h0005);
    alu(16'h0001, 16'h0002, 16'h0000);
    test_done();
  end
endmodule
